// File: pkg/mpsg_pkg.sv
`default_nettype none

package mpsg_pkg;

	// ****************************************************************
	// Pin group layout
	// ****************************************************************
	localparam int unsigned NUM_GPIO      = 8;
	localparam int unsigned FIRST_GPIO    = 8;
	localparam int unsigned MODE_W        = 2;
	localparam logic [7:0]  IRQ_PIN_MASK  = 8'h0F;
	localparam logic [7:0]  PWR_PIN_MASK  = 8'h0D;
	localparam int unsigned PWR_BIT_A     = 0;
	localparam int unsigned PWR_BIT_B     = 2;
	localparam int unsigned PWR_BIT_C     = 3;

	// ****************************************************************
	// Strap encodings and reset values
	// ****************************************************************
	localparam logic        STRAP_SRC_CRYSTAL  = 1'h0;
	localparam logic        STRAP_SRC_EXTERNAL = 1'h1;
	localparam logic [1:0]  CLK_SEL_24MHZ      = 2'h0;
	localparam logic [1:0]  CLK_SEL_RST        = 2'h0;
	localparam logic        EDGE_RISING        = 1'h0;
	localparam logic        EDGE_FALLING       = 1'h1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned RST_MIN_NS     = 1000;
	localparam int unsigned RST_MIN_CYC    = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_CNT_W      = 9;

	typedef enum logic [MODE_W-1:0] {
		MODE_INPUT,
		MODE_IRQ,
		MODE_OUTPUT
	} mpsg_mode_t;

	// Illegal mode code falls back to input so a pin is never driven by accident.
	function automatic logic mode_drives(input logic [MODE_W-1:0] code);
		return (code == MODE_W'(MODE_OUTPUT));
	endfunction : mode_drives

	function automatic logic mode_irq(input logic [MODE_W-1:0] code);
		return (code == MODE_W'(MODE_IRQ));
	endfunction : mode_irq

endpackage : mpsg_pkg

`default_nettype wire

// File: hw/mpsg_gpio_cell.sv
`default_nettype none

module mpsg_gpio_cell #(
	parameter bit HAS_IRQ = 1'b1,
	parameter bit HAS_PWR = 1'b0
) (
	input  wire logic                        core_clk_i,  // Core clock
	input  wire logic                        sys_rst_i,   // Async reset, high
	input  wire logic                        chip_hold_i, // Chip held in reset
	input  wire logic [mpsg_pkg::MODE_W-1:0] mode_i,      // Pin mode code
	input  wire logic                        out_val_i,   // Output level
	input  wire logic                        pwr_en_i,    // Card power function
	input  wire logic                        edge_sel_i,  // 0 rising, 1 falling
	input  wire logic                        irq_clr_i,   // Clear pending edge
	input  wire logic                        pin_i,       // Pin level
	output logic                             pin_o,       // Pin drive level
	output logic                             pin_oe_n_o,  // Low while driving
	output logic                             in_val_o,    // Sampled pin level
	output logic                             irq_pend_o,  // Sticky edge flag
	output logic                             pwr_on_o     // Card power active
);

	logic pwr_sel;
	logic edge_hit;
	logic chip_hold;

	assign chip_hold = chip_hold_i;
	assign pwr_sel   = HAS_PWR && pwr_en_i && !chip_hold;
	assign edge_hit  = (edge_sel_i == mpsg_pkg::EDGE_RISING) ? (pin_i && !in_val_o) : (!pin_i && in_val_o);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_val_o <= 1'b0;
		end else begin
			in_val_o <= pin_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_o      <= 1'b0;
			pin_oe_n_o <= 1'b1;
			pwr_on_o   <= 1'b0;
		end else if (pwr_sel) begin
			pin_o      <= 1'b1;
			pin_oe_n_o <= 1'b0;
			pwr_on_o   <= 1'b1;
		end else begin
			pin_o      <= out_val_i;
			pin_oe_n_o <= chip_hold || !mpsg_pkg::mode_drives(mode_i);
			pwr_on_o   <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_pend_o <= 1'b0;
		end else if (chip_hold || !HAS_IRQ) begin
			irq_pend_o <= 1'b0;
		end else if (mpsg_pkg::mode_irq(mode_i) && !pwr_sel && edge_hit) begin
			irq_pend_o <= 1'b1;
		end else if (irq_clr_i) begin
			irq_pend_o <= 1'b0;
		end
	end

	property p_irq_set;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(HAS_IRQ && !chip_hold && !pwr_sel && mpsg_pkg::mode_irq(mode_i) && edge_hit) |=> irq_pend_o;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("edge in interrupt mode not flagged");

	property p_no_irq;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!HAS_IRQ |-> !irq_pend_o;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt flag on plain pin");

	property p_out_drive;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(!chip_hold && !pwr_sel && mpsg_pkg::mode_drives(mode_i)) |=> (!pin_oe_n_o && pin_o == $past(out_val_i));
	endproperty
	a_out_drive: assert property (p_out_drive) else $error("output mode not driving pin");

	property p_pwr_drive;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		pwr_sel |=> (pin_o && !pin_oe_n_o && pwr_on_o);
	endproperty
	a_pwr_drive: assert property (p_pwr_drive) else $error("card power not supplied");

endmodule : mpsg_gpio_cell

`default_nettype wire

// File: hw/mpsg_pin_logic.sv

`default_nettype none

module mpsg_pin_logic #(
	parameter int unsigned RST_MIN_CYC = mpsg_pkg::RST_MIN_CYC
) (
	input  wire logic                   core_clk_i,              // Core clock
	input  wire logic                   sys_rst_i,               // Async reset, high
	input  wire logic                   chip_reset_low_i,        // Chip reset pin, low active
	input  wire logic                   clock_source_strap_i,    // Clock source strap pin
	input  wire logic [1:0]             clk_freq_strap_i,        // Clock frequency strap pins
	input  wire logic                   mcu_standby_i,           // Controller in standby
	input  wire logic [15:0]            gpio_mode_i,             // Two bits per pin
	input  wire logic [7:0]             gpio_out_val_i,          // Output levels
	input  wire logic [7:0]             gpio_edge_sel_i,         // Edge select per pin
	input  wire logic [7:0]             gpio_irq_clr_i,          // Clear pending edge
	input  wire logic [2:0]             card_power_en_i,         // Power function a, b, c
	input  wire logic [7:0]             gpio_pin_i,              // Pin levels
	output logic      [7:0]             gpio_pin_o,              // Pin drive levels
	output logic      [7:0]             gpio_pin_oe_n_o,         // Low while driving
	output logic      [7:0]             gpio_in_val_o,           // Sampled pin levels
	output logic      [7:0]             gpio_irq_pend_o,         // Sticky edge flags
	output logic                        card_power_out_a_o,      // Slot power a on
	output logic                        card_power_out_b_o,      // Slot power b on
	output logic                        card_power_out_c_o,      // Slot power c on
	output logic                        chip_in_reset_o,         // Chip held in reset
	output logic                        strap_pulldown_en_o,     // Source strap pull-down
	output logic                        clk_source_external_o,   // External clock chosen
	output logic                        crystal_osc_en_o,        // Crystal driver on
	output logic      [1:0]             clk_freq_sel_o,          // Latched frequency strap
	output logic                        clk_24mhz_sel_o,         // 24 MHz selected
	output logic                        clk_sel_reserved_o,      // Reserved strap seen
	output logic                        rst_pulse_short_o,       // Last reset pulse too short
	output logic                        ext_mem_chip_enable_low_o // Memory enable, low active
);

	// ****************************************************************
	// Chip reset pin
	// ****************************************************************
	logic                                rst_low_prev_reg;
	logic [mpsg_pkg::RST_CNT_W-1:0]      rst_cnt_reg;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chip_in_reset_o  <= 1'b1;
			// Idle level of the pin is high, so no false release is seen after reset.
			rst_low_prev_reg <= 1'b1;
		end else begin
			chip_in_reset_o  <= !chip_reset_low_i;
			rst_low_prev_reg <= chip_reset_low_i;
		end
	end

	// A pulse shorter than the board must give is still honoured, but flagged,
	// because straps caught from such a pulse may not have settled.
	// pulse width check
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_cnt_reg       <= '0;
			rst_pulse_short_o <= 1'b0;
		end else if (!chip_reset_low_i) begin
			if (rst_cnt_reg < mpsg_pkg::RST_CNT_W'(RST_MIN_CYC)) begin
				rst_cnt_reg <= rst_cnt_reg + 1'b1;
			end
		end else if (!rst_low_prev_reg) begin
			rst_cnt_reg       <= '0;
			rst_pulse_short_o <= (rst_cnt_reg < mpsg_pkg::RST_CNT_W'(RST_MIN_CYC));
		end
	end

	// ****************************************************************
	// Clock straps
	// ****************************************************************
	// The strap registers follow the pins every cycle the chip reset is low,
	// so the value kept at release is the last one seen during reset.
	// strap latch
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_source_external_o <= mpsg_pkg::STRAP_SRC_CRYSTAL;
			crystal_osc_en_o      <= 1'b1;
			clk_freq_sel_o        <= mpsg_pkg::CLK_SEL_RST;
			clk_24mhz_sel_o       <= 1'b1;
			clk_sel_reserved_o    <= 1'b0;
		end else if (!chip_reset_low_i) begin
			clk_source_external_o <= clock_source_strap_i;
			crystal_osc_en_o      <= (clock_source_strap_i == mpsg_pkg::STRAP_SRC_CRYSTAL);
			clk_freq_sel_o        <= clk_freq_strap_i;
			clk_24mhz_sel_o       <= (clk_freq_strap_i == mpsg_pkg::CLK_SEL_24MHZ);
			clk_sel_reserved_o    <= (clk_freq_strap_i != mpsg_pkg::CLK_SEL_24MHZ);
		end
	end

	// The pull-down drops one cycle after release, once the strap is held.
	// strap pull-down
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_pulldown_en_o <= 1'b1;
		end else begin
			strap_pulldown_en_o <= !chip_reset_low_i;
		end
	end

	// ****************************************************************
	// External memory enable
	// ****************************************************************
	// memory enable
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_mem_chip_enable_low_o <= 1'b0;
		end else begin
			ext_mem_chip_enable_low_o <= mcu_standby_i;
		end
	end

	// ****************************************************************
	// General-purpose pins
	// ****************************************************************
	logic [7:0] pwr_en_map;
	logic [7:0] pwr_on;

	always_comb begin
		pwr_en_map                      = '0;
		pwr_en_map[mpsg_pkg::PWR_BIT_A] = card_power_en_i[0];
		pwr_en_map[mpsg_pkg::PWR_BIT_B] = card_power_en_i[1];
		pwr_en_map[mpsg_pkg::PWR_BIT_C] = card_power_en_i[2];
	end

	for (genvar g = 0; g < mpsg_pkg::NUM_GPIO; g++) begin : g_pin
		mpsg_gpio_cell #(
			.HAS_IRQ (mpsg_pkg::IRQ_PIN_MASK[g]),
			.HAS_PWR (mpsg_pkg::PWR_PIN_MASK[g])
		) u_cell (
			.core_clk_i  (core_clk_i),
			.sys_rst_i   (sys_rst_i),
			.chip_hold_i (chip_in_reset_o),
			.mode_i      (gpio_mode_i[g*mpsg_pkg::MODE_W +: mpsg_pkg::MODE_W]),
			.out_val_i   (gpio_out_val_i[g]),
			.pwr_en_i    (pwr_en_map[g]),
			.edge_sel_i  (gpio_edge_sel_i[g]),
			.irq_clr_i   (gpio_irq_clr_i[g]),
			.pin_i       (gpio_pin_i[g]),
			.pin_o       (gpio_pin_o[g]),
			.pin_oe_n_o  (gpio_pin_oe_n_o[g]),
			.in_val_o    (gpio_in_val_o[g]),
			.irq_pend_o  (gpio_irq_pend_o[g]),
			.pwr_on_o    (pwr_on[g])
		);
	end

	assign card_power_out_a_o = pwr_on[mpsg_pkg::PWR_BIT_A];
	assign card_power_out_b_o = pwr_on[mpsg_pkg::PWR_BIT_B];
	assign card_power_out_c_o = pwr_on[mpsg_pkg::PWR_BIT_C];

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_rst_hold;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!chip_reset_low_i |=> chip_in_reset_o ##1 (gpio_pin_oe_n_o == 8'hFF && !card_power_out_a_o
			&& !card_power_out_b_o && !card_power_out_c_o);
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("chip not held in reset");

	property p_strap_sample;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!chip_reset_low_i |=> (clk_source_external_o == $past(clock_source_strap_i)
			&& clk_freq_sel_o == $past(clk_freq_strap_i));
	endproperty
	a_strap_sample: assert property (p_strap_sample) else $error("straps not sampled in reset");

	property p_strap_hold;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		chip_reset_low_i |=> ($stable(clk_source_external_o) && $stable(clk_freq_sel_o));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("latched strap changed");

	property p_pd_release;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!chip_reset_low_i ##1 chip_reset_low_i |-> strap_pulldown_en_o ##1 !strap_pulldown_en_o;
	endproperty
	a_pd_release: assert property (p_pd_release) else $error("pull-down not released after latch");

	property p_src_decode;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		crystal_osc_en_o == (clk_source_external_o == mpsg_pkg::STRAP_SRC_CRYSTAL);
	endproperty
	a_src_decode: assert property (p_src_decode) else $error("clock source decode wrong");

	property p_freq_decode;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(clk_24mhz_sel_o == (clk_freq_sel_o == 2'h0)) && (clk_sel_reserved_o != clk_24mhz_sel_o);
	endproperty
	a_freq_decode: assert property (p_freq_decode) else $error("frequency strap decode wrong");

	property p_mem_enable;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 (ext_mem_chip_enable_low_o == $past(mcu_standby_i));
	endproperty
	a_mem_enable: assert property (p_mem_enable) else $error("memory enable does not follow standby");

	property p_short_pulse;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(chip_reset_low_i) && rst_cnt_reg < 9'(RST_MIN_CYC) |=> rst_pulse_short_o;
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("short reset pulse not flagged");

endmodule : mpsg_pin_logic

`default_nettype wire

// File: dv/mpsg_board_model.sv
`default_nettype none

module mpsg_board_model (
	input  wire logic       core_clk_i,       // Core clock
	input  wire logic       go_i,             // Start a reset pulse
	input  wire logic [7:0] len_i,            // Pulse length in cycles
	input  wire logic       src_i,            // Source strap wiring
	input  wire logic [1:0] freq_i,           // Frequency strap wiring
	input  wire logic [7:0] ext_i,            // Board level on released pins
	input  wire logic [7:0] pin_drv_i,        // Device drive levels
	input  wire logic [7:0] oe_n_i,           // Device drive enables, low active
	output logic            chip_reset_low_o, // Chip reset pin
	output logic            strap_src_o,      // Source strap pin
	output logic [1:0]      strap_freq_o,     // Frequency strap pins
	output logic [7:0]      pin_lvl_o         // Resolved pin levels
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Reset source and strap wiring
	// ****************************************************************
	logic [7:0] cnt_reg = 8'h00;

	always_ff @(posedge core_clk_i) begin
		if (go_i && cnt_reg == 8'h00) begin
			cnt_reg <= len_i;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
	assign chip_reset_low_o = (cnt_reg == 8'h00);

	assign strap_src_o  = src_i;
	assign strap_freq_o = freq_i;

	// A pin the device releases shows the board level, never the last driven value.
	always_comb begin
		for (int g = 0; g < 8; g++) begin
			pin_lvl_o[g] = oe_n_i[g] ? ext_i[g] : pin_drv_i[g];
		end
	end
endmodule : mpsg_board_model

`default_nettype wire

// File: dv/test_misc_pin_strap_and_gpio.sv
`default_nettype none

module test_misc_pin_strap_and_gpio;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	localparam int unsigned SIM_RST = 4;
	typedef struct packed {
		logic [15:0] mode; logic [7:0] outv; logic [2:0] pwr; logic [7:0] ext;
		logic [7:0] oe_n; logic [7:0] drv; logic [7:0] inv; logic [2:0] pon;
	} mpsg_row_t;
	localparam mpsg_row_t ROWS [4] = '{
		'{16'hAAAA, 8'h5A, 3'h0, 8'h00, 8'h00, 8'h5A, 8'h5A, 3'h0},
		'{16'h0000, 8'hFF, 3'h0, 8'hC3, 8'hFF, 8'h00, 8'hC3, 3'h0},
		'{16'hFFFF, 8'hFF, 3'h7, 8'h00, 8'hF2, 8'h0D, 8'h0D, 3'h7},
		'{16'h5555, 8'hFF, 3'h0, 8'h0F, 8'hFF, 8'h00, 8'h0F, 3'h0}
	};
	logic        core_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        mcu_standby_i = 1'b0;
	logic        go = 1'b0;
	logic        src = 1'b0;
	logic [1:0]  freq = 2'h0;
	logic [7:0]  len = 8'h04;
	logic [7:0]  ext = 8'h00;
	logic [15:0] gpio_mode_i = 16'h0000;
	logic [7:0]  gpio_out_val_i = 8'h00, gpio_edge_sel_i = 8'h00, gpio_irq_clr_i = 8'h00;
	logic [2:0]  card_power_en_i = 3'h0;
	logic        chip_reset_low_i, clock_source_strap_i;
	logic [1:0]  clk_freq_strap_i, clk_freq_sel_o;
	logic [7:0]  gpio_pin_i, gpio_pin_o, gpio_pin_oe_n_o, gpio_in_val_o, gpio_irq_pend_o;
	logic        card_power_out_a_o, card_power_out_b_o, card_power_out_c_o, chip_in_reset_o;
	logic        strap_pulldown_en_o, clk_source_external_o, crystal_osc_en_o, clk_24mhz_sel_o;
	logic        clk_sel_reserved_o, rst_pulse_short_o, ext_mem_chip_enable_low_o;
	int          n_fail = 0;
	int          samples_checked = 0;

	mpsg_pin_logic #(.RST_MIN_CYC(SIM_RST)) dut_u (
		.core_clk_i, .sys_rst_i, .chip_reset_low_i, .clock_source_strap_i, .clk_freq_strap_i,
		.mcu_standby_i, .gpio_mode_i, .gpio_out_val_i, .gpio_edge_sel_i, .gpio_irq_clr_i,
		.card_power_en_i, .gpio_pin_i, .gpio_pin_o, .gpio_pin_oe_n_o, .gpio_in_val_o,
		.gpio_irq_pend_o, .card_power_out_a_o, .card_power_out_b_o, .card_power_out_c_o,
		.chip_in_reset_o, .strap_pulldown_en_o, .clk_source_external_o, .crystal_osc_en_o,
		.clk_freq_sel_o, .clk_24mhz_sel_o, .clk_sel_reserved_o, .rst_pulse_short_o,
		.ext_mem_chip_enable_low_o
	);

	mpsg_board_model board_u (
		.core_clk_i(core_clk_i), .go_i(go), .len_i(len), .src_i(src), .freq_i(freq), .ext_i(ext),
		.pin_drv_i(gpio_pin_o), .oe_n_i(gpio_pin_oe_n_o), .chip_reset_low_o(chip_reset_low_i),
		.strap_src_o(clock_source_strap_i), .strap_freq_o(clk_freq_strap_i), .pin_lvl_o(gpio_pin_i)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic clks(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : clks

	task automatic results;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// Pulses shorter than three cycles would end before the mid-pulse checks.
	task automatic pulse(input logic [7:0] n, input logic s, input logic [1:0] f);
		clks(1);
		len <= n;
		src <= s;
		freq <= f;
		go <= 1'b1;
		clks(1);
		go <= 1'b0;
		clks(3);
		#1;
		chk("chip_in_reset", 8'(chip_in_reset_o), 8'h01);
		chk("pulldown held", 8'(strap_pulldown_en_o), 8'h01);
		chk("oe_n in reset", gpio_pin_oe_n_o, 8'hFF);
		clks(n + 6);
		#1;
		chk("chip released", 8'(chip_in_reset_o), 8'h00);
		chk("clk source", 8'(clk_source_external_o), 8'(s));
		chk("crystal", 8'(crystal_osc_en_o), 8'(!s));
		chk("freq sel", 8'(clk_freq_sel_o), 8'(f));
		chk("sel 24mhz", 8'(clk_24mhz_sel_o), 8'(f == 2'h0));
		chk("reserved", 8'(clk_sel_reserved_o), 8'(f != 2'h0));
		chk("pulldown off", 8'(strap_pulldown_en_o), 8'h00);
		chk("pulse short", 8'(rst_pulse_short_o), 8'(n < SIM_RST));
		clks(1);
		src <= !s;
		freq <= ~f;
		clks(4);
		#1;
		chk("source held", 8'(clk_source_external_o), 8'(s));
		chk("freq held", 8'(clk_freq_sel_o), 8'(f));
	endtask : pulse

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// The whole sequence takes about 160 cycles, so this leaves wide margin.
	initial begin
		#20000;
		n_fail++;
		results();
	end

	initial begin
		clks(10);
		#1;
		chk("oe_n reset", gpio_pin_oe_n_o, 8'hFF);
		chk("pulldown reset", 8'(strap_pulldown_en_o), 8'h01);
		chk("mem enable reset", 8'(ext_mem_chip_enable_low_o), 8'h00);
		clks(10);
		sys_rst_i <= 1'b0;
		foreach (ROWS[i]) begin
			clks(1);
			gpio_mode_i <= ROWS[i].mode;
			gpio_out_val_i <= ROWS[i].outv;
			card_power_en_i <= ROWS[i].pwr;
			ext <= ROWS[i].ext;
			clks(3);
			#1;
			chk("oe_n", gpio_pin_oe_n_o, ROWS[i].oe_n);
			chk("drive", gpio_pin_o & ~ROWS[i].oe_n, ROWS[i].drv);
			chk("in_val", gpio_in_val_o, ROWS[i].inv);
			chk("power", 8'({card_power_out_c_o, card_power_out_b_o, card_power_out_a_o}), 8'(ROWS[i].pon));
		end
		chk("pulse short idle", 8'(rst_pulse_short_o), 8'h00);
		clks(1);
		gpio_mode_i <= 16'hAAAA;
		pulse(8'h04, 1'b0, 2'h0);
		pulse(8'h04, 1'b1, 2'h0);
		pulse(8'h03, 1'b1, 2'h2);
		pulse(8'h06, 1'b0, 2'h3);
		pulse(8'h05, 1'b0, 2'h1);
		clks(1);
		gpio_mode_i <= 16'h0105;
		gpio_edge_sel_i <= 8'h02;
		ext <= 8'h02;
		gpio_irq_clr_i <= 8'hFF;
		clks(3);
		gpio_irq_clr_i <= 8'h00;
		clks(2);
		ext <= 8'h11;
		clks(3);
		#1;
		chk("pend edges", gpio_irq_pend_o, 8'h03);
		clks(1);
		ext <= 8'h00;
		gpio_irq_clr_i <= 8'h01;
		clks(3);
		#1;
		chk("pend clear", gpio_irq_pend_o, 8'h02);
		clks(1);
		mcu_standby_i <= 1'b1;
		clks(3);
		#1;
		chk("mem standby", 8'(ext_mem_chip_enable_low_o), 8'h01);
		clks(1);
		mcu_standby_i <= 1'b0;
		clks(3);
		#1;
		chk("mem active", 8'(ext_mem_chip_enable_low_o), 8'h00);
		results();
	end
endmodule : test_misc_pin_strap_and_gpio

`default_nettype wire
